//--- hw/mdio_pkg.sv
package mdio_pkg;

  // clock and pulse timing
  localparam int unsigned CLK_PERIOD_PS  = 5000;
  localparam int unsigned PULSE_W_PS     = 200000000;
  localparam int unsigned PULSE_W_CYC    = PULSE_W_PS / CLK_PERIOD_PS;
  localparam int unsigned PULSES_PER_REV = 30;

  // terminal and data counts
  localparam int unsigned N_IN   = 5;
  localparam int unsigned N_OUT  = 2;
  localparam int unsigned N_DATA = 4;

  // load factor display limits, percent
  localparam logic [7:0] LOAD_MIN_PCT = 8'h28;
  localparam logic [7:0] LOAD_MAX_PCT = 8'hc8;

  // overload warning level, percent of rated current
  localparam logic [7:0] OVL_LVL_MIN = 8'h32;
  localparam logic [7:0] OVL_LVL_MAX = 8'h78;
  localparam logic [7:0] OVL_LVL_RST = 8'h78;

  // speed attainment band, r/min
  localparam logic [8:0] BAND_MAX = 9'h190;
  localparam logic [8:0] BAND_RST = 9'h0c8;

  // operation data reset values: 50 r/min, 0.5 s in 0.1 s units
  localparam logic [12:0] DATA_SPEED_RST = 13'h0032;
  localparam logic [7:0]  DATA_TIME_RST  = 8'h05;

  // display codes; values arbitrary
  localparam logic [7:0]  ALM_CODE_NONE  = 8'h00;
  localparam logic [7:0]  ALM_CODE_EXT   = 8'h6e;
  localparam logic [7:0]  ALM_CODE_OVL   = 8'h30;
  localparam logic [15:0] DISP_LOAD_DASH = 16'hfffe;
  localparam logic [15:0] DISP_LOAD_HOLD = 16'hfffd;

  typedef enum logic [2:0] {
    IFN_NONE      = 3'h0,
    IFN_RUN_FWD   = 3'h1,
    IFN_RUN_BWD   = 3'h2,
    IFN_SEL_LO    = 3'h3,
    IFN_SEL_HI    = 3'h4,
    IFN_CLEAR     = 3'h5,
    IFN_EXT_FAULT = 3'h6,
    IFN_HOLD_FREE = 3'h7
  } mdio_in_fn_t;

  typedef enum logic [2:0] {
    OFN_NONE     = 3'h0,
    OFN_FAULT    = 3'h1,
    OFN_SPEED    = 3'h2,
    OFN_OVERLOAD = 3'h3,
    OFN_MOTION   = 3'h4,
    OFN_REACHED  = 3'h5,
    OFN_WARNING  = 3'h6
  } mdio_out_fn_t;

  // gray along speed -> load -> data -> alarm -> warning -> io
  typedef enum logic [2:0] {
    VIEW_SPEED = 3'b000,
    VIEW_LOAD  = 3'b001,
    VIEW_DATA  = 3'b011,
    VIEW_ALARM = 3'b010,
    VIEW_WARN  = 3'b110,
    VIEW_IO    = 3'b111
  } mdio_view_t;

  typedef struct packed {
    logic [12:0] speed;
    logic [7:0]  accel;
    logic [7:0]  decel;
  } mdio_data_t;

  typedef struct packed {
    mdio_view_t  view;
    logic [15:0] value;
    logic        blink;
  } mdio_disp_t;

endpackage

//--- hw/mdio_core.sv
`timescale 1ns/1ps

// Functional notes
// - exactly one of forward/reverse run asserted runs motor that way.
// - both run inputs asserted together stop the motor instantly.
// - data number from two select inputs; both off selects number zero.
// - fault clear input clears the active alarm.
// - external fault is active low; off raises alarm, instant stop, code shown.
// - with position keeping enabled, hold release drops standstill torque.
// - fault output normally closed; opens on alarm.
// - speed pulse: 30 per output shaft turn, each 0.2 ms wide.
// - overload output normally closed; opens above warning level or overload alarm.
// - motion output asserted while motor operates.
// - speed reached when speed is within the attainment band of set speed.
// - warning output follows warning, motor keeps running, clears itself.
// - function on several terminals executes when any of them is active.
// - load view in 1% steps 40..200%, dash below 40%.
// - position keeping enabled shows hold indication in load view.
// - data view shows currently selected operation data number.
// - alarm shows its code; reset and alarm history view/clear from there.
// - warning shows its code; warning history view/clear from there.
// - io view lights one segment per terminal that is on.
// - speed view after power-up by default; initial view is selectable.
// - each input terminal carries its configured function, or none.
// - four operation data sets of speed, acceleration, deceleration.
// - overload warning level configurable 50..120%, default 120.
// - attainment band configurable 0..400 r/min, default 200.
module mdio_core
  import mdio_pkg::*;
#(
  parameter int unsigned PULSE_CYC = PULSE_W_CYC
) (
  input  wire logic             sys_clk,
  input  wire logic             rst_b,
  input  wire logic             input_terminal_zero,
  input  wire logic             input_terminal_one,
  input  wire logic             input_terminal_two,
  input  wire logic             input_terminal_three,
  input  wire logic             input_terminal_four,
  input  wire mdio_in_fn_t      in_fn_sel [N_IN],
  input  wire mdio_out_fn_t     out_fn_sel [N_OUT],
  input  wire logic             hold_enable,
  input  wire logic [7:0]       ovl_level,
  input  wire logic [8:0]       speed_band,
  input  wire mdio_view_t       init_view,
  input  wire logic             view_next,
  input  wire logic             alarm_hist_clear,
  input  wire logic             warn_hist_clear,
  input  wire logic             data_wr_en,
  input  wire logic [1:0]       data_wr_idx,
  input  wire mdio_data_t       data_wr_val,
  input  wire logic             rotor_tick,
  input  wire logic [12:0]      motor_speed,
  input  wire logic [7:0]       load_pct,
  input  wire logic             overload_alarm,
  input  wire logic             warning_cond,
  input  wire logic [7:0]       warning_code,
  output logic                  motor_run,
  output logic                  motor_dir_bwd,
  output logic                  stop_instant,
  output logic                  hold_torque,
  output logic                  fault_out,
  output logic                  overload_out,
  output logic                  speed_pulse_out,
  output logic                  motion_active,
  output logic                  speed_reached,
  output logic                  warning_out,
  output logic                  output_terminal_zero,
  output logic                  output_terminal_one,
  output logic [1:0]            data_num,
  output mdio_data_t            sel_data,
  output mdio_disp_t            disp,
  output logic [7:0]            alarm_hist,
  output logic [7:0]            warn_hist,
  output logic [6:0]            io_status
);

  typedef struct packed {
    logic [N_IN-1:0]         meta;
    logic [N_IN-1:0]         term;
    logic                    clr_prev;
    logic                    view_prev;
    logic                    alarm;
    logic [7:0]              alarm_code;
    logic [7:0]              alarm_hist;
    logic                    warn;
    logic [7:0]              warn_hist;
    mdio_view_t              view;
    logic [15:0]             pulse_cnt;
    logic                    pulse;
    logic                    run;
    logic                    dir_bwd;
    logic                    stop_inst;
    logic                    hold;
    logic                    fault_n;
    logic                    ovl_n;
    logic                    motion;
    logic                    reached;
    logic [1:0]              data_num;
    mdio_data_t [N_DATA-1:0] data;
    mdio_data_t              sel;
    mdio_disp_t              disp;
    logic [N_OUT-1:0]        out_term;
  } mdio_state_t;

  mdio_state_t st_q;
  mdio_state_t st_d;

  logic [N_IN-1:0] pins;
  logic [7:0]      fn_on  [N_IN];
  logic [7:0]      fn_off [N_IN];
  logic [7:0]      fn_any;
  logic [7:0]      ext_off_any;
  logic [N_OUT-1:0] out_val;

  assign pins = {input_terminal_four, input_terminal_three, input_terminal_two,
                 input_terminal_one, input_terminal_zero};

  // per-terminal function decode, on and off levels
  for (genvar t = 0; t < N_IN; t++) begin : g_term
    assign fn_on[t]  = st_q.term[t]  ? (8'h01 << in_fn_sel[t]) : 8'h00;
    assign fn_off[t] = !st_q.term[t] ? (8'h01 << in_fn_sel[t]) : 8'h00;
  end

  always_comb begin
    fn_any      = 8'h00;
    ext_off_any = 8'h00;
    for (int t = 0; t < N_IN; t++) begin
      fn_any      = fn_any | fn_on[t];
      ext_off_any = ext_off_any | fn_off[t];
    end
    fn_any[IFN_NONE] = 1'b0;
  end

  // output terminal routing, one mux per terminal
  for (genvar o = 0; o < N_OUT; o++) begin : g_out
    always_comb begin
      case (out_fn_sel[o])
        OFN_FAULT:    out_val[o] = st_q.fault_n;
        OFN_SPEED:    out_val[o] = st_q.pulse;
        OFN_OVERLOAD: out_val[o] = st_q.ovl_n;
        OFN_MOTION:   out_val[o] = st_q.motion;
        OFN_REACHED:  out_val[o] = st_q.reached;
        OFN_WARNING:  out_val[o] = st_q.warn;
        default:      out_val[o] = 1'b0;
      endcase
    end
  end

  logic        run_forward;
  logic        bwd;
  logic        ext_fault;
  logic        clr_rise;
  logic [13:0] speed_diff;
  logic [7:0]  ovl_lvl_c;
  logic [8:0]  band_c;

  always_comb begin
    st_d = st_q;
    run_forward       = fn_any[IFN_RUN_FWD];
    bwd       = fn_any[IFN_RUN_BWD];
    ext_fault = ext_off_any[IFN_EXT_FAULT];
    clr_rise  = fn_any[IFN_CLEAR] && !st_q.clr_prev;
    // configuration clamped to its legal range
    ovl_lvl_c = (ovl_level < OVL_LVL_MIN) ? OVL_LVL_MIN :
                (ovl_level > OVL_LVL_MAX) ? OVL_LVL_MAX : ovl_level;
    band_c    = (speed_band > BAND_MAX) ? BAND_MAX : speed_band;
    speed_diff = (motor_speed >= st_q.sel.speed) ?
                 {1'b0, motor_speed - st_q.sel.speed} :
                 {1'b0, st_q.sel.speed - motor_speed};

    st_d.meta      = pins;
    st_d.term      = st_q.meta;
    st_d.clr_prev  = fn_any[IFN_CLEAR];
    st_d.view_prev = view_next;

    // alarm: a standing cause wins over the clear
    if (clr_rise) begin
      st_d.alarm      = 1'b0;
      st_d.alarm_code = ALM_CODE_NONE;
    end
    if (ext_fault) begin
      st_d.alarm      = 1'b1;
      st_d.alarm_code = ALM_CODE_EXT;
    end else if (overload_alarm) begin
      st_d.alarm      = 1'b1;
      st_d.alarm_code = ALM_CODE_OVL;
    end
    if (alarm_hist_clear) begin
      st_d.alarm_hist = ALM_CODE_NONE;
    end
    if (st_d.alarm && !st_q.alarm) begin
      st_d.alarm_hist = st_d.alarm_code;
    end

    st_d.warn = warning_cond;
    if (warn_hist_clear) begin
      st_d.warn_hist = ALM_CODE_NONE;
    end
    if (warning_cond && !st_q.warn) begin
      st_d.warn_hist = warning_code;
    end

    // run control; both inputs or an alarm stop without ramp
    st_d.stop_inst = (run_forward && bwd) || st_d.alarm;
    st_d.run       = (run_forward ^ bwd) && !st_d.alarm;
    if (run_forward ^ bwd) begin
      st_d.dir_bwd = bwd;
    end
    st_d.hold = hold_enable && !st_d.run && !fn_any[IFN_HOLD_FREE];

    st_d.data_num = {fn_any[IFN_SEL_HI], fn_any[IFN_SEL_LO]};
    if (data_wr_en) begin
      st_d.data[data_wr_idx] = data_wr_val;
    end
    st_d.sel = st_q.data[st_q.data_num];

    st_d.fault_n = !st_d.alarm;
    st_d.ovl_n   = !((load_pct > ovl_lvl_c) || overload_alarm);
    st_d.motion  = motor_speed != 13'h0000;
    st_d.reached = st_q.motion && (speed_diff <= {5'h00, band_c});

    // one fixed-width pulse per rotor tick; ticks inside a pulse are merged
    if (st_q.pulse_cnt != 16'h0000) begin
      st_d.pulse_cnt = st_q.pulse_cnt - 16'h0001;
    end else if (rotor_tick) begin
      st_d.pulse_cnt = PULSE_CYC[15:0];
    end
    st_d.pulse = st_d.pulse_cnt != 16'h0000;

    st_d.out_term = out_val;

    // view sequencing; a new alarm or warning jumps to its code view
    if (view_next && !st_q.view_prev) begin
      case (st_q.view)
        VIEW_SPEED: st_d.view = VIEW_LOAD;
        VIEW_LOAD:  st_d.view = VIEW_DATA;
        VIEW_DATA:  st_d.view = VIEW_ALARM;
        VIEW_ALARM: st_d.view = VIEW_WARN;
        VIEW_WARN:  st_d.view = VIEW_IO;
        VIEW_IO:    st_d.view = VIEW_SPEED;
        default:    st_d.view = VIEW_SPEED;
      endcase
    end
    if (st_d.alarm && !st_q.alarm) begin
      st_d.view = VIEW_ALARM;
    end else if (warning_cond && !st_q.warn) begin
      st_d.view = VIEW_WARN;
    end

    st_d.disp.view  = st_q.view;
    st_d.disp.blink = st_q.alarm && (st_q.view != VIEW_ALARM);
    case (st_q.view)
      VIEW_SPEED: st_d.disp.value = {3'h0, motor_speed};
      VIEW_LOAD: begin
        if (hold_enable) begin
          st_d.disp.value = DISP_LOAD_HOLD;
        end else if (load_pct < LOAD_MIN_PCT) begin
          st_d.disp.value = DISP_LOAD_DASH;
        end else if (load_pct > LOAD_MAX_PCT) begin
          st_d.disp.value = {8'h00, LOAD_MAX_PCT};
        end else begin
          st_d.disp.value = {8'h00, load_pct};
        end
      end
      VIEW_DATA:  st_d.disp.value = {14'h0000, st_q.data_num};
      VIEW_ALARM: st_d.disp.value = {8'h00, st_q.alarm_code};
      VIEW_WARN:  st_d.disp.value = {8'h00, st_q.warn ? warning_code : 8'h00};
      VIEW_IO:    st_d.disp.value = {9'h000, st_q.out_term, st_q.term};
      default:    st_d.disp.value = 16'h0000;
    endcase

    if (!rst_b) begin
      st_d            = '0;
      // sync keeps tracking pins: a zeroed stage would read as an ext fault at release
      st_d.meta       = pins;
      st_d.term       = st_q.meta;
      st_d.fault_n    = 1'b1;
      st_d.ovl_n      = 1'b1;
      st_d.view       = init_view;
      st_d.disp.view  = init_view;
      for (int i = 0; i < N_DATA; i++) begin
        st_d.data[i] = '{speed: DATA_SPEED_RST, accel: DATA_TIME_RST, decel: DATA_TIME_RST};
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    st_q <= st_d;
  end

  assign motor_run            = st_q.run;
  assign motor_dir_bwd        = st_q.dir_bwd;
  assign stop_instant         = st_q.stop_inst;
  assign hold_torque          = st_q.hold;
  assign fault_out            = st_q.fault_n;
  assign overload_out         = st_q.ovl_n;
  assign speed_pulse_out      = st_q.pulse;
  assign motion_active        = st_q.motion;
  assign speed_reached        = st_q.reached;
  assign warning_out          = st_q.warn;
  assign output_terminal_zero = st_q.out_term[0];
  assign output_terminal_one  = st_q.out_term[1];
  assign data_num             = st_q.data_num;
  assign sel_data             = st_q.sel;
  assign disp                 = st_q.disp;
  assign alarm_hist           = st_q.alarm_hist;
  assign warn_hist            = st_q.warn_hist;
  assign io_status            = {st_q.out_term, st_q.term};

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);

  sequence s_tick_idle;
    rotor_tick && st_q.pulse_cnt == 16'h0000;
  endsequence

  sequence s_pulse_high;
    speed_pulse_out [*8];
  endsequence

  // pulse width tracked by a helper counter
  logic [15:0] hi_cnt;
  always_ff @(posedge sys_clk) begin
    if (!rst_b || !speed_pulse_out) begin
      hi_cnt <= 16'h0000;
    end else begin
      hi_cnt <= hi_cnt + 16'h0001;
    end
  end

  chk_pulse_start: assert property (s_tick_idle |=> s_pulse_high)
    else $error("speed pulse did not start on rotor tick");
  chk_pulse_width: assert property ($fell(speed_pulse_out)
                                    |-> $past(hi_cnt) == PULSE_CYC[15:0] - 16'h0001)
    else $error("speed pulse width wrong");
  chk_both_stop: assert property (fn_any[IFN_RUN_FWD] && fn_any[IFN_RUN_BWD]
                                  |=> stop_instant && !motor_run)
    else $error("both run inputs did not stop instantly");
  chk_single_run: assert property ((fn_any[IFN_RUN_FWD] ^ fn_any[IFN_RUN_BWD]) && !st_d.alarm
                                   |=> motor_run && motor_dir_bwd == $past(fn_any[IFN_RUN_BWD]))
    else $error("single run input did not run the motor");
  chk_ext_alarm: assert property (ext_off_any[IFN_EXT_FAULT] |=> !fault_out && stop_instant
                                  && st_q.alarm_code == ALM_CODE_EXT)
    else $error("external fault did not raise alarm");
  chk_clear_alarm: assert property (st_q.alarm && fn_any[IFN_CLEAR] && !st_q.clr_prev
                                    && !ext_off_any[IFN_EXT_FAULT] && !overload_alarm |=> fault_out)
    else $error("fault clear did not clear alarm");
  chk_data_num: assert property (##1 data_num == {$past(fn_any[IFN_SEL_HI]), $past(fn_any[IFN_SEL_LO])})
    else $error("data number mismatch");
  chk_warn_follow: assert property ($fell(warning_cond) |=> !warning_out ##0 motor_run == $past(st_d.run))
    else $error("warning output did not follow condition");
  chk_load_dash: assert property (st_q.view == VIEW_LOAD && !hold_enable && load_pct < LOAD_MIN_PCT
                                  |=> disp.value == DISP_LOAD_DASH)
    else $error("load dash not shown");
  chk_overload_open: assert property (load_pct > OVL_LVL_MAX |=> !overload_out)
    else $error("overload output did not open");

endmodule

//--- test/mdio_plc_model.sv
`timescale 1ns/1ps
module mdio_plc_model
  import mdio_pkg::*;
(
  input  wire logic        sys_clk,
  input  wire logic [4:0]  cmd,
  input  wire logic        pulse_in,
  output logic [4:0]       term,
  output int unsigned      pulse_width,
  output int unsigned      pulse_count
);
  logic [4:0]  term_q  = 5'h10;
  int unsigned run_len = 0;
  int unsigned width_q = 0;
  int unsigned count_q = 0;
  assign term        = term_q;
  assign pulse_width = width_q;
  assign pulse_count = count_q;
  // switch contacts move just after an edge, held until the next command
  always @(posedge sys_clk) begin
    term_q <= cmd;
  end
  // high-time count lets the controller reckon speed as freq * 60 / 30
  always @(posedge sys_clk) begin
    if (pulse_in) begin
      run_len <= run_len + 1;
    end else if (run_len != 0) begin
      width_q <= run_len;
      count_q <= count_q + 1;
      run_len <= 0;
    end
  end
endmodule

//--- test/motor_driver_io_logic_tb_top.sv
`timescale 1ns/1ps
module motor_driver_io_logic_tb_top
  import mdio_pkg::*;
;
  localparam int PCYC = 10;
  logic sys_clk = 1'b0, rst_b = 1'b0, hold_enable = 1'b0, view_next = 1'b0;
  logic alarm_hist_clear = 1'b0, warn_hist_clear = 1'b0, data_wr_en = 1'b0, rotor_tick = 1'b0;
  logic overload_alarm = 1'b0, warning_cond = 1'b0;
  logic [4:0] cmd = 5'h10, term;
  logic [7:0] ovl_level = 8'h78, load_pct = 8'h00, warning_code = 8'h00, alarm_hist, warn_hist;
  logic [8:0] speed_band = 9'h0c8;
  logic [1:0] data_wr_idx = 2'h0, data_num;
  logic [12:0] motor_speed = 13'h0000;
  logic [6:0] io_status;
  logic motor_run, motor_dir_bwd, stop_instant, hold_torque, fault_out, overload_out, speed_pulse_out;
  logic motion_active, speed_reached, warning_out, out_zero, out_one;
  mdio_data_t data_wr_val = '0, sel_data;
  mdio_disp_t disp;
  mdio_view_t init_view = VIEW_SPEED;
  mdio_in_fn_t in_fn [N_IN];
  mdio_out_fn_t out_fn [N_OUT];
  int unsigned pulse_width, pulse_count, cnt0;
  int bad_count = 0, num_checks = 0, cycles = 0;
  logic [7:0] loads [4] = '{8'h1e, 8'h28, 8'h96, 8'hfa};
  logic [15:0] shown [4] = '{16'hfffe, 16'h0028, 16'h0096, 16'h00c8};

  always #2.5 sys_clk = ~sys_clk;

  mdio_core #(.PULSE_CYC(PCYC)) uut (
    .sys_clk(sys_clk), .rst_b(rst_b), .input_terminal_zero(term[0]), .input_terminal_one(term[1]),
    .input_terminal_two(term[2]), .input_terminal_three(term[3]), .input_terminal_four(term[4]),
    .in_fn_sel(in_fn), .out_fn_sel(out_fn), .hold_enable(hold_enable), .ovl_level(ovl_level),
    .speed_band(speed_band), .init_view(init_view), .view_next(view_next),
    .alarm_hist_clear(alarm_hist_clear), .warn_hist_clear(warn_hist_clear), .data_wr_en(data_wr_en),
    .data_wr_idx(data_wr_idx), .data_wr_val(data_wr_val), .rotor_tick(rotor_tick),
    .motor_speed(motor_speed), .load_pct(load_pct), .overload_alarm(overload_alarm),
    .warning_cond(warning_cond), .warning_code(warning_code), .motor_run(motor_run),
    .motor_dir_bwd(motor_dir_bwd), .stop_instant(stop_instant), .hold_torque(hold_torque),
    .fault_out(fault_out), .overload_out(overload_out), .speed_pulse_out(speed_pulse_out),
    .motion_active(motion_active), .speed_reached(speed_reached), .warning_out(warning_out),
    .output_terminal_zero(out_zero), .output_terminal_one(out_one), .data_num(data_num),
    .sel_data(sel_data), .disp(disp), .alarm_hist(alarm_hist), .warn_hist(warn_hist),
    .io_status(io_status)
  );

  mdio_plc_model plc (
    .sys_clk(sys_clk), .cmd(cmd), .pulse_in(out_one), .term(term),
    .pulse_width(pulse_width), .pulse_count(pulse_count)
  );

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic print_verdict();
    if (bad_count == 0 && num_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge sys_clk);
  endtask

  task automatic do_reset(input mdio_view_t v);
    init_view = v;
    rst_b = 1'b0;
    cyc(16);
    rst_b = 1'b1;
    cyc(4);
  endtask

  // two sync flops plus model and output register need settling time
  task automatic set_term(input logic [4:0] v);
    cmd = v;
    cyc(6);
  endtask

  task automatic write_data(input logic [1:0] idx, input logic [12:0] spd);
    data_wr_idx = idx;
    data_wr_val = '{speed: spd, accel: 8'h05, decel: 8'h05};
    data_wr_en = 1'b1;
    cyc(1);
    data_wr_en = 1'b0;
    cyc(1);
  endtask

  task automatic tick();
    rotor_tick = 1'b1;
    cyc(1);
    rotor_tick = 1'b0;
  endtask

  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 20000) begin
      bad_count++;
      print_verdict();
    end
  end

  initial begin
    in_fn = '{IFN_RUN_FWD, IFN_RUN_BWD, IFN_SEL_LO, IFN_SEL_HI, IFN_EXT_FAULT};
    out_fn = '{OFN_FAULT, OFN_SPEED};
    do_reset(VIEW_SPEED);
    check(fault_out, 1);
    check(overload_out, 1);
    check(disp.view, VIEW_SPEED);
    set_term(5'h11);
    check({motor_run, motor_dir_bwd}, 2'b10);
    set_term(5'h12);
    check({motor_run, motor_dir_bwd}, 2'b11);
    set_term(5'h13);
    check({motor_run, stop_instant}, 2'b01);
    check(io_status[4:0], 5'h13);
    for (int n = 0; n < 4; n++) write_data(n[1:0], 13'h0100 + 13'(n));
    for (int n = 0; n < 4; n++) begin
      set_term({1'b1, n[1:0], 2'b00});
      check(data_num, n[1:0]);
      check(sel_data.speed, 13'h0100 + 13'(n));
    end
    set_term(5'h01);
    check({fault_out, out_zero, motor_run, stop_instant}, 4'b0001);
    check(disp.view, VIEW_ALARM);
    check(alarm_hist, ALM_CODE_EXT);
    view_next = 1'b1;
    cyc(1);
    view_next = 1'b0;
    cyc(2);
    check({disp.view, disp.blink}, {VIEW_WARN, 1'b1});
    in_fn[2] = IFN_CLEAR;
    set_term(5'h04);
    check(fault_out, 0);
    set_term(5'h10);
    set_term(5'h14);
    check(fault_out, 1);
    alarm_hist_clear = 1'b1;
    cyc(2);
    alarm_hist_clear = 1'b0;
    cyc(2);
    check(alarm_hist, ALM_CODE_NONE);
    set_term(5'h18);
    in_fn[3] = IFN_EXT_FAULT;
    set_term(5'h10);
    check(fault_out, 0);
    in_fn[3] = IFN_SEL_HI;
    set_term(5'h14);
    check(fault_out, 1);
    tick();
    cyc(PCYC + 4);
    check(pulse_width, PCYC);
    cnt0 = pulse_count;
    tick();
    cyc(3);
    tick();
    cyc(PCYC + 4);
    check(pulse_count, cnt0 + 1);
    set_term(5'h11);
    motor_speed = 13'h0064;
    cyc(4);
    check({motion_active, speed_reached}, 2'b11);
    motor_speed = 13'h0500;
    cyc(4);
    check(speed_reached, 0);
    speed_band = 9'h000;
    motor_speed = 13'h0100;
    cyc(4);
    check(speed_reached, 1);
    load_pct = 8'h82;
    cyc(3);
    check(overload_out, 0);
    ovl_level = 8'h0a;
    load_pct = 8'h3c;
    cyc(3);
    check(overload_out, 0);
    ovl_level = 8'h78;
    cyc(3);
    check(overload_out, 1);
    warning_code = 8'h21;
    warning_cond = 1'b1;
    cyc(4);
    check({warning_out, motor_run, fault_out}, 3'b111);
    check({disp.view, warn_hist}, {VIEW_WARN, 8'h21});
    warning_cond = 1'b0;
    warn_hist_clear = 1'b1;
    cyc(4);
    warn_hist_clear = 1'b0;
    check({warning_out, warn_hist}, 9'h000);
    overload_alarm = 1'b1;
    cyc(4);
    check({overload_out, fault_out}, 2'b00);
    overload_alarm = 1'b0;
    set_term(5'h10);
    set_term(5'h14);
    check({overload_out, fault_out}, 2'b11);
    motor_speed = 13'h0000;
    load_pct = 8'h00;
    set_term(5'h10);
    do_reset(VIEW_LOAD);
    check(disp.view, VIEW_LOAD);
    for (int i = 0; i < 4; i++) begin
      load_pct = loads[i];
      cyc(3);
      check(disp.value, shown[i]);
    end
    hold_enable = 1'b1;
    cyc(3);
    check({disp.value, hold_torque}, {DISP_LOAD_HOLD, 1'b1});
    in_fn[1] = IFN_HOLD_FREE;
    set_term(5'h12);
    check(hold_torque, 0);
    print_verdict();
  end
endmodule
